//--- logic/spc_pkg.sv
// constants shared by the serial port configuration block
package spc_pkg;
    localparam int ADDR_W = 13;
    localparam int INSTR_W = 16;
    localparam logic [12:0] OFS_PORT_CFG = 13'h0000;
    localparam logic [12:0] OFS_VARIANT_ID = 13'h0003;
    localparam logic [12:0] OFS_READBACK_SEL = 13'h0004;
    localparam logic [12:0] OFS_UPDATE = 13'h0232;
    // port configuration, update and readback select fields
    localparam int POS_PIN_SEL = 0;
    localparam int POS_LSB_FIRST = 1;
    localparam int POS_SOFT_RST = 2;
    localparam int POS_LONG_INSTR = 3;
    localparam int POS_UPDATE = 0;
    localparam int POS_RB_ACTIVE = 0;
    // values after reset: long instruction set, mirrored into bit 4
    localparam logic [7:0] RST_PORT_CFG = 8'h18;
    localparam logic [7:0] RST_READBACK_SEL = 8'h00;
    // variant code: value is arbitrary
    localparam logic [7:0] VARIANT_CODE = 8'h5A;
endpackage

//--- logic/spc_sync.sv
// two-stage synchroniser for one pin level
`timescale 1ns/10ps
`default_nettype none
module spc_sync (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    logic meta_q;

    // first stage is read only by the second
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end
        else if (ce)
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

//--- logic/spc_port.sv
// serial control port with its configuration and readback registers
//
// Summary of operation
// RULE_01 - host mirrors low nibble reversed into upper
// RULE_02 - host keeps long instruction bit at one
// RULE_03 - reset leaves sixteen-bit instructions selected
// RULE_04 - soft reset bit holds defaults until cleared
// RULE_05 - bit order zero: msb first, address decrements
// RULE_06 - bit order one: lsb first, address increments
// RULE_07 - pin select zero: data pin both ways
// RULE_08 - pin select one: reads on separate pin
// RULE_09 - read-only variant byte ignores writes
// RULE_10 - readback select picks buffer or active set
// RULE_11 - writes land in buffer until update
`timescale 1ns/10ps
`default_nettype none
module spc_port (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe_n,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_n,
    output logic [7:0] active_cfg_q,
    output logic [7:0] active_rb_q
);
    typedef enum {ST_IDLE, ST_INSTR, ST_DATA} spc_state_e;
    spc_state_e state_q;
    logic sclk_s, cs_n_s, sdi_s, sclk_p_q;
    logic [15:0] sh_q;
    logic [4:0] cnt_q;
    logic [12:0] addr_q;
    logic rd_q;
    logic [7:0] cfg_q, rb_q, tx_q, rdata;
    logic rise, fall, soft_rst;
    logic [7:0] rx_byte;
    logic cs_s, rb_active, lsb_first, pin_sel;

    spc_sync u_sclk (.mclk(mclk), .srst(srst), .ce(ce), .d(sclk), .q(sclk_s));
    // select passes as active high, so reset reads as deselected
    spc_sync u_cs (.mclk(mclk), .srst(srst), .ce(ce), .d(!cs_n), .q(cs_s));
    assign cs_n_s = !cs_s;
    spc_sync u_sdi (.mclk(mclk), .srst(srst), .ce(ce), .d(sdio_i),
        .q(sdi_s));

    // edge detect on the synchronised clock only
    always_ff @(posedge mclk)
    begin
        if (srst)
            sclk_p_q <= 1'b0;
        else if (ce)
            sclk_p_q <= sclk_s;
    end

    assign rise = ce && !cs_n_s && sclk_s && !sclk_p_q;
    assign fall = ce && !cs_n_s && !sclk_s && sclk_p_q;
    assign soft_rst = cfg_q[spc_pkg::POS_SOFT_RST]; // [RULE_04]

    // active copy steers the port; buffer writes wait for update
    assign lsb_first = active_cfg_q[spc_pkg::POS_LSB_FIRST]; // [RULE_11]
    assign pin_sel = active_cfg_q[spc_pkg::POS_PIN_SEL];
    assign rb_active = active_rb_q[spc_pkg::POS_RB_ACTIVE]; // [RULE_10]

    // incoming byte is bit-reversed when lsb first
    always_comb
    begin
        rx_byte = {sh_q[6:0], sdi_s};
        if (lsb_first) // [RULE_06]
            rx_byte = {<<{rx_byte}};
    end

    // readback mux; unmapped addresses read zero
    always_comb
    begin
        rdata = 8'h00;
        case (addr_q)
            spc_pkg::OFS_PORT_CFG: rdata = rb_active
                ? active_cfg_q : cfg_q; // [RULE_10]
            spc_pkg::OFS_VARIANT_ID: rdata = spc_pkg::VARIANT_CODE;
            spc_pkg::OFS_READBACK_SEL: rdata = rb_active
                ? active_rb_q : rb_q; // [RULE_10]
            default: rdata = 8'h00;
        endcase
    end

    // frame sequencer: instruction then bytes, address stepping
    always_ff @(posedge mclk)
    begin
        if (srst || (ce && cs_n_s))
        begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            sh_q <= 16'h0000;
            addr_q <= 13'h0000;
            rd_q <= 1'b0;
        end
        else if (ce)
        begin
            case (state_q)
                ST_IDLE:
                    state_q <= ST_INSTR;
                ST_INSTR:
                    if (rise)
                    begin
                        sh_q <= {sh_q[14:0], sdi_s};
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == 5'h0F) // [RULE_03]
                        begin
                            rd_q <= sh_q[14];
                            addr_q <= {sh_q[11:0], sdi_s};
                            cnt_q <= 5'h00;
                            state_q <= ST_DATA;
                        end
                    end
                ST_DATA:
                    if (rise)
                    begin
                        sh_q <= {sh_q[14:0], sdi_s};
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == 5'h07)
                        begin
                            cnt_q <= 5'h00;
                            if (lsb_first)
                                addr_q <= addr_q + 13'h0001; // [RULE_06]
                            else
                                addr_q <= addr_q - 13'h0001; // [RULE_05]
                        end
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // buffer registers take serial writes; soft reset holds the readback buffer at defaults
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cfg_q <= spc_pkg::RST_PORT_CFG; // [RULE_03]
            rb_q <= spc_pkg::RST_READBACK_SEL;
        end
        else if (ce && state_q == ST_DATA && rise && cnt_q == 5'h07
            && !rd_q)
        begin
            if (addr_q == spc_pkg::OFS_PORT_CFG)
                cfg_q <= rx_byte; // [RULE_11]
            else if (soft_rst)
                rb_q <= spc_pkg::RST_READBACK_SEL; // [RULE_04]
            else if (addr_q == spc_pkg::OFS_READBACK_SEL)
                rb_q <= rx_byte; // [RULE_11]
            // variant byte has no storage: writes fall away [RULE_09]
        end
        else if (ce && soft_rst)
            rb_q <= spc_pkg::RST_READBACK_SEL; // [RULE_04]
    end

    // active set follows buffer only on the update command
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            active_cfg_q <= spc_pkg::RST_PORT_CFG;
            active_rb_q <= spc_pkg::RST_READBACK_SEL;
        end
        else if (ce && soft_rst)
        begin
            active_cfg_q <= spc_pkg::RST_PORT_CFG; // [RULE_04]
            active_rb_q <= spc_pkg::RST_READBACK_SEL;
        end
        else if (ce && state_q == ST_DATA && rise && cnt_q == 5'h07
            && !rd_q && addr_q == spc_pkg::OFS_UPDATE
            && rx_byte[spc_pkg::POS_UPDATE])
        begin
            active_cfg_q <= cfg_q; // [RULE_11]
            active_rb_q <= rb_q;
        end
    end

    // read shifter: load byte at each byte boundary, shift on falling edge
    always_ff @(posedge mclk)
    begin
        if (srst || (ce && cs_n_s))
            tx_q <= 8'h00;
        else if (ce && rd_q && state_q == ST_DATA && fall)
        begin
            if (cnt_q == 5'h00)
                tx_q <= lsb_first
                    ? {<<{rdata}} : rdata; // [RULE_05] [RULE_06]
            else
                tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // pin steering; separate output stays released in bidirectional mode
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            sdio_o <= 1'b0;
            sdio_oe_n <= 1'b1;
            serial_out_pin_o <= 1'b0;
            serial_out_pin_oe_n <= 1'b1;
        end
        else if (ce)
        begin
            sdio_o <= tx_q[7];
            serial_out_pin_o <= tx_q[7];
            sdio_oe_n <= !(rd_q && state_q == ST_DATA && !cs_n_s
                && !pin_sel); // [RULE_07]
            serial_out_pin_oe_n <= !(rd_q && state_q == ST_DATA && !cs_n_s
                && pin_sel); // [RULE_08]
        end
    end

    // pin select one never drives the data pin
    pin_excl_a: assert property (@(posedge mclk) // [RULE_08]
        disable iff (srst) pin_sel |=> sdio_oe_n)
        else $error("data pin driven in unidirectional mode");
    // pin select zero keeps the separate output released
    sep_hiz_a: assert property (@(posedge mclk) // [RULE_07]
        disable iff (srst) !pin_sel |=> serial_out_pin_oe_n)
        else $error("separate output driven in bidirectional mode");
    long_reset_a: assert property (@(posedge mclk) // [RULE_03]
        $past(srst) |-> cfg_q[spc_pkg::POS_LONG_INSTR])
        else $error("long instruction bit clear after reset");
    soft_hold_a: assert property (@(posedge mclk) // [RULE_04]
        disable iff (srst)
        soft_rst && ce |=> active_rb_q == spc_pkg::RST_READBACK_SEL)
        else $error("soft reset did not restore defaults");
    addr_down_a: assert property (@(posedge mclk) // [RULE_05]
        disable iff (srst)
        state_q == ST_DATA && rise && cnt_q == 5'h07 && !lsb_first |=>
        addr_q == $past(addr_q) - 13'h0001)
        else $error("address did not decrement");
    addr_up_a: assert property (@(posedge mclk) // [RULE_06]
        disable iff (srst)
        state_q == ST_DATA && rise && cnt_q == 5'h07 && lsb_first |=>
        addr_q == $past(addr_q) + 13'h0001)
        else $error("address did not increment");
    active_hold_a: assert property (@(posedge mclk) // [RULE_11]
        disable iff (srst)
        !soft_rst && !(state_q == ST_DATA && addr_q == spc_pkg::OFS_UPDATE)
        |=> $stable(active_cfg_q))
        else $error("active set changed without update");
    // the read shifter must pick up the fixed variant byte
    id_read_a: assert property (@(posedge mclk) // [RULE_09]
        disable iff (srst)
        rd_q && state_q == ST_DATA && fall && cnt_q == 5'h00 && !lsb_first
        && addr_q == spc_pkg::OFS_VARIANT_ID |=>
        tx_q == spc_pkg::VARIANT_CODE)
        else $error("variant byte not loaded for readback");
    rb_sel_a: assert property (@(posedge mclk) // [RULE_10]
        disable iff (srst)
        addr_q == spc_pkg::OFS_PORT_CFG && rb_active
        |-> rdata == active_cfg_q)
        else $error("readback did not select active set");
endmodule
`default_nettype wire

//--- bench/spc_host.sv
// host model that drives the serial control port frames
`timescale 1ns/10ps
`default_nettype none
module spc_host (
    input wire logic mclk,
    output logic sclk,
    output logic cs_n,
    output logic sdio_w,
    input wire logic sdio_o,
    input wire logic sdio_oe_n,
    input wire logic so_o,
    input wire logic so_oe_n
);
    logic hd = 1'b0;
    logic rel = 1'b0;
    logic so_w;
    int sd_drv = 0;
    int so_drv = 0;
    // released pins toggle so a stale value cannot pass
    assign sdio_w = sdio_oe_n ? hd : sdio_o;
    assign so_w = so_oe_n ? ~hd : so_o;
    // count cycles in which the device drives either pin
    always @(posedge mclk)
    begin
        if (rel)
            hd <= ~hd;
        if (!sdio_oe_n)
            sd_drv <= sd_drv + 1;
        if (!so_oe_n)
            so_drv <= so_drv + 1;
    end
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // one frame: instruction, then nb bytes; serial clock idles low
    task automatic xfer(input logic rd, input logic [12:0] a,
        input int nb, input logic [15:0] wd, input logic lsb,
        output logic [15:0] rsd, output logic [15:0] rso);
        logic [15:0] ins;
        int i;
        int x;
        ins = {rd, 2'b00, a};
        rsd = 16'h0000;
        rso = 16'h0000;
        cs_n = 1'b0;
        sd_drv = 0;
        so_drv = 0;
        tick(4);
        for (i = 0; i < 16 + 8 * nb; i++)
        begin
            x = 15 - 8 * ((i - 16) / 8);
            x = x - (lsb ? 7 - (i - 16) % 8 : (i - 16) % 8);
            if (i < 16)
                hd = ins[15 - i];
            else if (!rd)
                hd = wd[x];
            rel = rd && i >= 16;
            tick(4);
            sclk = 1'b1;
            tick(4);
            if (i >= 16)
            begin
                rsd[x] = sdio_w;
                rso[x] = so_w;
            end
            sclk = 1'b0;
        end
        tick(4);
        cs_n = 1'b1;
        rel = 1'b0;
        tick(8);
    endtask
endmodule
`default_nettype wire

//--- bench/spc_port_test.sv
// self-checking bench for the serial port configuration block
`timescale 1ns/10ps
`default_nettype none
module spc_port_test;
    logic mclk, srst, sclk, cs_n, sdio_i, sdio_o, sdio_oe_n, so_o, so_oe_n;
    logic [7:0] active_cfg_q, active_rb_q;
    logic [15:0] rsd, rso;
    logic lsb;
    int bad_count = 0;
    int comparisons = 0;
    always #25 mclk = ~mclk;
    spc_port dut (.mclk(mclk), .srst(srst), .ce(1'b1), .sclk(sclk),
        .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o),
        .sdio_oe_n(sdio_oe_n), .serial_out_pin_o(so_o),
        .serial_out_pin_oe_n(so_oe_n), .active_cfg_q(active_cfg_q),
        .active_rb_q(active_rb_q));
    spc_host host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .sdio_w(sdio_i),
        .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n), .so_o(so_o),
        .so_oe_n(so_oe_n));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
        input string what);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what,
                got, exp);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, 1, {d, 8'h00}, lsb, rsd, rso);
    endtask
    task automatic rd(input logic [12:0] a, input int nb);
        host.xfer(1'b1, a, nb, 16'h0000, lsb, rsd, rso);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard: a run far past its length counts as a mismatch
    initial
    begin
        repeat (100000) @(posedge mclk);
        bad_count++;
        results;
    end
    initial
    begin
        mclk = 1'b0;
        srst = 1'b1;
        lsb = 1'b0;
        repeat (20) @(negedge mclk);
        srst = 1'b0;
        repeat (4) @(negedge mclk);
        chk8(active_cfg_q, 8'h18, "active cfg");
        rd(13'h0000, 1);
        chk8(rsd[15:8], 8'h18, "cfg read");
        chk8(8'(host.so_drv), 8'h00, "sep out idle");
        chk8(8'(host.sd_drv > 0), 8'h01, "sdio drive");
        wr(13'h0003, 8'hFF);
        rd(13'h0004, 2);
        chk8(rsd[15:8], 8'h00, "rb default");
        chk8(rsd[7:0], 8'h5A, "variant");
        $display("test defaults done");
        wr(13'h0004, 8'h01);
        chk8(active_rb_q, 8'h00, "rb held");
        rd(13'h0004, 1);
        chk8(rsd[15:8], 8'h01, "buffer read");
        wr(13'h0232, 8'h01);
        chk8(active_rb_q, 8'h01, "rb updated");
        wr(13'h0004, 8'h00);
        rd(13'h0004, 1);
        chk8(rsd[15:8], 8'h01, "active read");
        wr(13'h0232, 8'h01);
        $display("test banks done");
        // mirrored value, so the order in force does not matter
        wr(13'h0000, 8'h5A);
        wr(13'h0232, 8'h01);
        lsb = 1'b1;
        wr(13'h0004, 8'h01);
        rd(13'h0003, 2);
        chk8(rsd[15:8], 8'h5A, "lsb variant");
        chk8(rsd[7:0], 8'h01, "lsb step");
        wr(13'h0000, 8'h99);
        wr(13'h0232, 8'h01);
        lsb = 1'b0;
        $display("test lsb first done");
        rd(13'h0003, 1);
        chk8(rso[15:8], 8'h5A, "sep out read");
        chk8(8'(host.sd_drv), 8'h00, "sdio quiet");
        $display("test unidirectional done");
        wr(13'h0004, 8'h01);
        wr(13'h0232, 8'h01);
        wr(13'h0000, 8'h3C);
        chk8(active_rb_q, 8'h00, "rb forced");
        wr(13'h0000, 8'h18);
        wr(13'h0232, 8'h01);
        chk8(active_rb_q, 8'h00, "rb after");
        chk8(active_cfg_q, 8'h18, "cfg after");
        rd(13'h0004, 1);
        chk8(rsd[15:8], 8'h00, "rb buffer");
        $display("test soft reset done");
        results;
    end
endmodule
`default_nettype wire
